// *** dtk_band.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dtk_regs.svh"
module dtk_band import dtk_pkg::*; #(
  parameter int RW = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic [RW-1:0] ratio,
  // Sequencer
  output var logic [2:0] slot,
  output var logic [1:0] sw,
  output var logic step
);

  if (RW < 8) begin : g_bad_rw
    $error("dtk_band: RW must hold a ratio of 128");
  end

  typedef struct packed {
    logic [RW-2:0] cnt;
    logic [2:0] slot;
    logic [1:0] sw;
    logic step;
  } dtk_band_st_t;

  dtk_band_st_t st_r;
  dtk_band_st_t st_nxt;

  function automatic logic [1:0] sw_of(input logic [2:0] s);
    unique case (s)
      3'h0, 3'h7: sw_of = `DTK_SW_NONE;
      3'h1, 3'h6: sw_of = `DTK_SW_FIRST;
      3'h2, 3'h5: sw_of = `DTK_SW_SECOND;
      default: sw_of = `DTK_SW_BOTH;
    endcase
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.step = 1'b0;
    if (!run) begin
      st_nxt = '0;
    end else if (tick) begin
      if (st_r.cnt == '0) begin
        st_nxt.cnt = (RW-1)'(ratio - RW'(1));
        st_nxt.slot = st_r.slot + 3'h1;
        st_nxt.step = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - (RW-1)'(1);
      end
    end
    st_nxt.sw = sw_of(st_nxt.slot);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign slot = st_r.slot;
  assign sw = st_r.sw;
  assign step = st_r.step;

  sequence s_step_seen;
    run ##1 step;
  endsequence

  a_ratio_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run |-> (ratio != '0 && ratio <= RW'(`DTK_N_MAX)))
    else $error("band ratio out of range");

  a_slot_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_step_seen |-> slot == $past(slot) + 3'h1)
    else $error("slot did not advance");

  a_sw_stair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (slot == 3'h3 || slot == 3'h4) |-> sw == `DTK_SW_BOTH)
    else $error("staircase peak code wrong");

endmodule
`default_nettype wire

// *** dtk_keypad.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtk_keypad import dtk_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Requested contacts
  input wire logic [3:0] row_req,
  input wire logic [3:0] col_req,
  // Key lines
  output var dtk_key_t keys
);
  // Released lines fall back to the inactive level
  initial keys = '0;
  always @(posedge ref_clk) begin
    keys <= #1 '{row: row_req, col: col_req};
  end
endmodule
`default_nettype wire

// *** dtk_pkg.sv ***
package dtk_pkg;

  typedef enum logic [10:0] {
    DTK_M_OFF    = 11'h001,
    DTK_M_DUAL   = 11'h002,
    DTK_M_ROW    = 11'h004,
    DTK_M_COL    = 11'h008,
    DTK_M_DC     = 11'h010,
    DTK_M_ROWSQ  = 11'h020,
    DTK_M_COLSQ  = 11'h040,
    DTK_M_902ROW = 11'h080,
    DTK_M_902    = 11'h100,
    DTK_M_902SQ  = 11'h200,
    DTK_M_LOCK   = 11'h400
  } dtk_mode_t;

  typedef struct packed {
    logic [3:0] row;
    logic [3:0] col;
  } dtk_key_t;

  typedef struct packed {
    logic oe;
    logic [2:0] level;
  } dtk_tone_t;

  typedef struct packed {
    logic o;
    logic oe;
  } dtk_od_t;

  typedef struct packed {
    logic [2:0] pre;
    dtk_mode_t mode;
    dtk_tone_t tone;
    dtk_od_t dis;
  } dtk_core_st_t;

endpackage

// *** dtk_regs.svh ***
`ifndef DTK_REGS_SVH
`define DTK_REGS_SVH

// Prescaler: crystal divided by eight
`define DTK_PRE_MAX 3'h7
`define DTK_PRE_DIV 8'h08

// Reference crystal, Hz
`define DTK_OSC_HZ 32'h0036_9E99

// Band counter ratios, low band rows 1..4
`define DTK_N_LO0 8'h50
`define DTK_N_LO1 8'h49
`define DTK_N_LO2 8'h42
`define DTK_N_LO3 8'h3B
// Band counter ratios, high band columns 1..4
`define DTK_N_HI0 8'h2E
`define DTK_N_HI1 8'h2A
`define DTK_N_HI2 8'h26
`define DTK_N_HI3 8'h22
// Ratio for the 902 Hz component
`define DTK_N_902 8'h3E
`define DTK_N_MAX 8'h80

// Nominal tones, Hz
`define DTK_F_LO0 16'h02B9
`define DTK_F_LO1 16'h0302
`define DTK_F_LO2 16'h0354
`define DTK_F_LO3 16'h03AD
`define DTK_F_HI0 16'h04B9
`define DTK_F_HI1 16'h0538
`define DTK_F_HI2 16'h05C5
`define DTK_F_HI3 16'h0661
`define DTK_F_902 16'h0386

// Tolerance in hundredths of a percent
`define DTK_TOL_CP 16'h004B

// Staircase switch codes per slot pair
`define DTK_SW_NONE 2'h0
`define DTK_SW_FIRST 2'h1
`define DTK_SW_SECOND 2'h2
`define DTK_SW_BOTH 2'h3

// Output levels
`define DTK_LVL_ZERO 3'h0
`define DTK_LVL_DC 3'h3
`define DTK_LVL_FULL 3'h6

`endif

// *** dtk_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtk_sync import dtk_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Keys
  input wire dtk_key_t keys_pin,
  output var dtk_key_t keys_sync
);

  typedef struct packed {
    dtk_key_t s1;
    dtk_key_t s2;
  } dtk_sync_st_t;

  dtk_sync_st_t st_r;
  dtk_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = keys_pin;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign keys_sync = st_r.s2;

endmodule
`default_nettype wire

// *** dtk_synth.sv ***
// Behaviour
// - Crystal clock divided by eight first
// - Two band dividers, ratio one to 128
// - Band output steps eight-slot staircase sequencer
// - Dual tone sums low and high levels
// - Oscillator gating selected by build parameter
// - Ratios chosen for 3.58 MHz crystal
// - All tones within 0.75 percent
// - No keys: output off, disable off
// - One row, one column: dual tone
// - One row, several columns: row tone
// - Several rows, one column: column tone
// - Several rows and columns: steady level
// - Four plus multiple: lockout steady level
// - Test modes: 50 percent square outputs
// - Rows without column add 902 Hz
// - Columns without row: output off
// - Row tones 697, 770, 852, 941
// - Column tones 1209, 1336, 1477, 1633
// - Ratio lookup per row and column
// - Two switch bits encode the staircase
`timescale 1ns/1ps
`default_nettype none
`include "dtk_regs.svh"
module dtk_synth import dtk_pkg::*; #(
  parameter bit OSC_GATE = 1'b0,
  parameter longint OSC_HZ = `DTK_OSC_HZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Keypad rows and columns, high when active
  input wire dtk_key_t keys_pin,
  // Tone output, oe low means high impedance
  output var dtk_tone_t tone,
  // Open-drain disable pin
  output var logic dis_o,
  output var logic dis_oe,
  // Oscillator running
  output var logic osc_run
);

  // Frequency check of every ratio against the crystal
  function automatic bit tol_ok(input longint n, input longint f);
    longint act;
    longint dev;
    act = (OSC_HZ * 10000) / (longint'(`DTK_PRE_DIV) * 8 * n);
    dev = act - f * 10000;
    if (dev < 0) begin
      dev = -dev;
    end
    tol_ok = (dev <= longint'(`DTK_TOL_CP) * f);
  endfunction

  if (!tol_ok(`DTK_N_LO0, `DTK_F_LO0) || !tol_ok(`DTK_N_LO1, `DTK_F_LO1) ||
      !tol_ok(`DTK_N_LO2, `DTK_F_LO2) || !tol_ok(`DTK_N_LO3, `DTK_F_LO3) ||
      !tol_ok(`DTK_N_HI0, `DTK_F_HI0) || !tol_ok(`DTK_N_HI1, `DTK_F_HI1) ||
      !tol_ok(`DTK_N_HI2, `DTK_F_HI2) || !tol_ok(`DTK_N_HI3, `DTK_F_HI3) ||
      !tol_ok(`DTK_N_902, `DTK_F_902)) begin : g_bad_osc
    $error("dtk_synth: OSC_HZ puts a tone outside tolerance");
  end

  dtk_key_t keys;
  dtk_core_st_t st_r;
  dtk_core_st_t st_nxt;
  logic tick;
  logic [2:0] nr;
  logic [2:0] nc;
  logic [1:0] row_idx;
  logic [1:0] col_idx;
  dtk_mode_t mode;
  logic lo_run;
  logic hi_run;
  logic [7:0] lo_ratio;
  logic [7:0] hi_ratio;
  logic [2:0] lo_slot;
  logic [2:0] hi_slot;
  logic [1:0] lo_sw;
  logic [1:0] hi_sw;
  logic [2:0] sum_lvl;

  dtk_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .keys_pin(keys_pin),
    .keys_sync(keys)
  );

  function automatic logic [2:0] pop4(input logic [3:0] v);
    pop4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // Lowest active line; callers use it only when one is active
  function automatic logic [1:0] idx4(input logic [3:0] v);
    idx4 = 2'h0;
    if (v[3]) begin
      idx4 = 2'h3;
    end
    if (v[2]) begin
      idx4 = 2'h2;
    end
    if (v[1]) begin
      idx4 = 2'h1;
    end
    if (v[0]) begin
      idx4 = 2'h0;
    end
  endfunction

  function automatic logic [7:0] lo_tab(input logic [1:0] i);
    unique case (i)
      2'h0: lo_tab = `DTK_N_LO0;
      2'h1: lo_tab = `DTK_N_LO1;
      2'h2: lo_tab = `DTK_N_LO2;
      2'h3: lo_tab = `DTK_N_LO3;
    endcase
  endfunction

  function automatic logic [7:0] hi_tab(input logic [1:0] i);
    unique case (i)
      2'h0: hi_tab = `DTK_N_HI0;
      2'h1: hi_tab = `DTK_N_HI1;
      2'h2: hi_tab = `DTK_N_HI2;
      2'h3: hi_tab = `DTK_N_HI3;
    endcase
  endfunction

  assign nr = pop4(keys.row);
  assign nc = pop4(keys.col);
  assign row_idx = idx4(keys.row);
  assign col_idx = idx4(keys.col);
  assign osc_run = !OSC_GATE || (keys.row != 4'h0);
  assign tick = osc_run && (st_r.pre == `DTK_PRE_MAX);

  // Key pattern to operating mode
  always_comb begin
    mode = DTK_M_OFF;
    if (nr == 3'h1) begin
      if (nc == 3'h0) begin
        mode = DTK_M_902ROW;
      end else if (nc == 3'h1) begin
        mode = DTK_M_DUAL;
      end else if (nc == 3'h4) begin
        mode = DTK_M_ROWSQ;
      end else begin
        mode = DTK_M_ROW;
      end
    end else if (nr == 3'h2 || nr == 3'h3) begin
      if (nc == 3'h0) begin
        mode = DTK_M_902;
      end else if (nc == 3'h1) begin
        mode = DTK_M_COL;
      end else if (nc == 3'h4) begin
        mode = DTK_M_LOCK;
      end else begin
        mode = DTK_M_DC;
      end
    end else if (nr == 3'h4) begin
      if (nc == 3'h0) begin
        mode = DTK_M_902SQ;
      end else if (nc == 3'h1) begin
        mode = DTK_M_COLSQ;
      end else begin
        mode = DTK_M_LOCK;
      end
    end
  end

  // Band enables and ratio lookup
  always_comb begin
    lo_run = 1'b0;
    hi_run = 1'b0;
    lo_ratio = lo_tab(row_idx);
    hi_ratio = hi_tab(col_idx);
    unique case (mode)
      DTK_M_DUAL: begin
        lo_run = 1'b1;
        hi_run = 1'b1;
      end
      DTK_M_ROW, DTK_M_ROWSQ: begin
        lo_run = 1'b1;
      end
      DTK_M_COL, DTK_M_COLSQ: begin
        hi_run = 1'b1;
      end
      DTK_M_902ROW: begin
        lo_run = 1'b1;
        hi_run = 1'b1;
        hi_ratio = `DTK_N_902;
      end
      DTK_M_902, DTK_M_902SQ: begin
        hi_run = 1'b1;
        hi_ratio = `DTK_N_902;
      end
      DTK_M_OFF, DTK_M_DC, DTK_M_LOCK: begin
      end
    endcase
  end

  dtk_band #(
    .RW(8)
  ) u_lo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(lo_run),
    .ratio(lo_ratio),
    .slot(lo_slot),
    .sw(lo_sw),
    .step()
  );

  dtk_band #(
    .RW(8)
  ) u_hi (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(hi_run),
    .ratio(hi_ratio),
    .slot(hi_slot),
    .sw(hi_sw),
    .step()
  );

  assign sum_lvl = 3'(lo_sw) + 3'(hi_sw);

  // Output stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.pre = osc_run ? st_r.pre + 3'h1 : 3'h0;
    st_nxt.mode = mode;
    st_nxt.dis.o = 1'b1;
    st_nxt.tone.oe = 1'b1;
    st_nxt.dis.oe = 1'b1;
    st_nxt.tone.level = `DTK_LVL_DC;
    unique case (mode)
      DTK_M_OFF: begin
        st_nxt.tone.oe = 1'b0;
        st_nxt.dis.oe = 1'b0;
        st_nxt.tone.level = `DTK_LVL_ZERO;
      end
      DTK_M_DUAL, DTK_M_902ROW: begin
        st_nxt.tone.level = sum_lvl;
      end
      DTK_M_ROW: begin
        st_nxt.tone.level = 3'(lo_sw);
      end
      DTK_M_COL, DTK_M_902: begin
        st_nxt.tone.level = 3'(hi_sw);
      end
      DTK_M_ROWSQ: begin
        st_nxt.tone.level = lo_slot[2] ? `DTK_LVL_FULL : `DTK_LVL_ZERO;
        st_nxt.dis.oe = lo_slot[2];
      end
      DTK_M_COLSQ, DTK_M_902SQ: begin
        st_nxt.tone.level = hi_slot[2] ? `DTK_LVL_FULL : `DTK_LVL_ZERO;
        st_nxt.dis.oe = hi_slot[2];
      end
      DTK_M_DC, DTK_M_LOCK: begin
        st_nxt.tone.level = `DTK_LVL_DC;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r <= '{pre: 3'h0, mode: DTK_M_OFF, tone: '0, dis: '{o: 1'b1, oe: 1'b0}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tone = st_r.tone;
  assign dis_o = st_r.dis.o;
  assign dis_oe = st_r.dis.oe;

  sequence s_no_row;
    keys.row == 4'h0;
  endsequence

  sequence s_one_one;
    nr == 3'h1 && nc == 3'h1;
  endsequence

  sequence s_one_multi;
    nr == 3'h1 && (nc == 3'h2 || nc == 3'h3);
  endsequence

  sequence s_multi_multi;
    (nr == 3'h2 || nr == 3'h3) && (nc == 3'h2 || nc == 3'h3);
  endsequence

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick ##1 osc_run[*8] |-> tick && !$past(tick))
    else $error("prescaler tick not every eight clocks");

  a_quiet_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_no_row |=> !tone.oe && !dis_oe)
    else $error("output not off without keys");

  a_cols_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_no_row and nc != 3'h0) |=> !tone.oe && !dis_oe && st_r.mode == DTK_M_OFF)
    else $error("columns alone produced output");

  a_dual_tone: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_one_one |-> lo_run && hi_run ##1 dis_oe && tone.level == $past(sum_lvl))
    else $error("dual tone not produced");

  a_row_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_one_multi |-> lo_run && !hi_run ##1 tone.level == 3'($past(lo_sw)) && dis_oe)
    else $error("row tone alone not produced");

  a_col_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((nr == 3'h2 || nr == 3'h3) && nc == 3'h1) |-> hi_run && !lo_run ##1 dis_oe)
    else $error("column tone alone not produced");

  a_dc_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_multi_multi[*2] |=> tone.level == `DTK_LVL_DC && tone.oe && dis_oe && $stable(tone.level))
    else $error("steady level not held");

  a_lockout: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (nr == 3'h4 && nc >= 3'h2) |-> !lo_run && !hi_run ##1 tone.level == `DTK_LVL_DC)
    else $error("lockout did not hold steady level");

  a_square_dis: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r.mode == DTK_M_ROWSQ || st_r.mode == DTK_M_COLSQ || st_r.mode == DTK_M_902SQ) |->
      (dis_oe ? tone.level == `DTK_LVL_FULL : tone.level == `DTK_LVL_ZERO))
    else $error("test square outputs disagree");

  a_902_ratio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (nr != 3'h0 && nc == 3'h0) |-> hi_run && hi_ratio == `DTK_N_902)
    else $error("902 Hz component missing");

  a_lo_lookup: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lo_run && keys.row == 4'h8) |-> lo_ratio == `DTK_N_LO3)
    else $error("low band ratio wrong for row four");

  a_gate_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_no_row and (OSC_GATE == 1'b1)) |=> st_r.pre == 3'h0)
    else $error("oscillator ran with no row");

endmodule
`default_nettype wire

// *** dtk_synth_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtk_synth_tb import dtk_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] row_req = 4'h0;
  logic [3:0] col_req = 4'h0;
  dtk_key_t keys;
  dtk_tone_t tone;
  logic dis_o;
  logic dis_oe;
  logic osc_run;
  logic osc_run_g;
  int fails = 0;
  int total_checks = 0;
  int lo_n[4] = '{80, 73, 66, 59};
  int hi_n[4] = '{46, 42, 38, 34};
  int lo_f[4] = '{697, 770, 852, 941};
  int hi_f[4] = '{1209, 1336, 1477, 1633};

  always #25 ref_clk = ~ref_clk;

  dtk_keypad kp (.ref_clk(ref_clk), .row_req(row_req), .col_req(col_req), .keys(keys));

  dtk_synth uut (.ref_clk(ref_clk), .rst_n(rst_n), .keys_pin(keys), .tone(tone), .dis_o(dis_o),
    .dis_oe(dis_oe), .osc_run(osc_run));

  // Variant whose oscillator runs only with a row active
  dtk_synth #(.OSC_GATE(1'b1)) uut_gated (.ref_clk(ref_clk), .rst_n(rst_n), .keys_pin(keys), .tone(), .dis_o(),
    .dis_oe(), .osc_run(osc_run_g));

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic press(input logic [3:0] r, input logic [3:0] c);
    @(posedge ref_clk);
    #1;
    row_req = r;
    col_req = c;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // One staircase period between rises from level zero
  task automatic measure(input int n, input int f, input bit sq);
    int p;
    int t;
    longint d;
    logic [2:0] prev;
    logic bad;
    p = -1;
    bad = 1'b0;
    prev = 3'h7;
    for (t = 0; t < 3 * 64 * n; t++) begin
      @(negedge ref_clk);
      if (tone.oe !== 1'b1) bad = 1'b1;
      if (sq && ((tone.level !== 3'h0 && tone.level !== 3'h6) || dis_oe !== (tone.level == 3'h6))) bad = 1'b1;
      if (!sq && dis_oe !== 1'b1) bad = 1'b1;
      if (prev === 3'h0 && tone.level !== 3'h0) begin
        if (p >= 0) break;
        p = 0;
      end
      if (p >= 0) p++;
      prev = tone.level;
    end
    chk_val(p, 64 * n);
    chk_bit(bad, 1'b0);
    d = (p > 0) ? (longint'(3579545) * 10000 / p - longint'(f) * 10000) : longint'(f) * 10000;
    chk_bit((d < 0 ? -d : d) <= 75 * f, 1'b1);
  endtask

  task automatic t_quiet();
    press(4'h0, 4'h0);
    chk_bit(tone.oe, 1'b0);
    chk_bit(dis_oe, 1'b0);
    chk_bit(dis_o, 1'b1);
    chk_bit(osc_run, 1'b1);
    chk_bit(osc_run_g, 1'b0);
    $display("test quiet done");
  endtask

  task automatic t_cols_only();
    press(4'h0, 4'h5);
    repeat (200) @(negedge ref_clk);
    chk_bit(tone.oe, 1'b0);
    chk_bit(dis_oe, 1'b0);
    $display("test cols_only done");
  endtask

  task automatic t_row_tone();
    for (int i = 0; i < 4; i++) begin
      press(4'h0, 4'h0);
      press(4'h1 << i, i[0] ? 4'hB : 4'h3);
      measure(lo_n[i], lo_f[i], 1'b0);
    end
    $display("test row_tone done");
  endtask

  task automatic t_col_tone();
    for (int j = 0; j < 4; j++) begin
      press(4'h0, 4'h0);
      press(j[0] ? 4'h7 : 4'h3, 4'h1 << j);
      measure(hi_n[j], hi_f[j], 1'b0);
    end
    $display("test col_tone done");
  endtask

  // Summed staircase must climb above one band's top code
  task automatic t_pair(input logic [3:0] r, input logic [3:0] c);
    logic [2:0] mx;
    logic bad;
    mx = 3'h0;
    bad = 1'b0;
    press(4'h0, 4'h0);
    press(r, c);
    repeat (3000) begin
      @(negedge ref_clk);
      if (tone.level > mx) mx = tone.level;
      if (tone.oe !== 1'b1 || dis_oe !== 1'b1 || tone.level > 3'h6) bad = 1'b1;
    end
    chk_bit(bad, 1'b0);
    chk_bit(mx >= 3'h4, 1'b1);
    $display("test pair done");
  endtask

  task automatic t_steady(input logic [3:0] r, input logic [3:0] c);
    logic bad;
    bad = 1'b0;
    press(r, c);
    repeat (400) begin
      @(negedge ref_clk);
      if (tone.level !== 3'h3 || tone.oe !== 1'b1 || dis_oe !== 1'b1) bad = 1'b1;
    end
    chk_bit(bad, 1'b0);
    $display("test steady done");
  endtask

  task automatic t_square();
    press(4'h0, 4'h0);
    press(4'h2, 4'hF);
    measure(lo_n[1], lo_f[1], 1'b1);
    press(4'h0, 4'h0);
    press(4'hF, 4'h4);
    measure(hi_n[2], hi_f[2], 1'b1);
    $display("test square done");
  endtask

  task automatic t_rows_only();
    press(4'h0, 4'h0);
    press(4'h6, 4'h0);
    chk_bit(osc_run_g, 1'b1);
    measure(62, 902, 1'b0);
    press(4'h0, 4'h0);
    press(4'hF, 4'h0);
    measure(62, 902, 1'b1);
    $display("test rows_only done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_quiet();
    t_cols_only();
    t_row_tone();
    t_col_tone();
    t_pair(4'h1, 4'h1);
    t_pair(4'h4, 4'h0);
    t_steady(4'h3, 4'h6);
    t_steady(4'hF, 4'h3);
    t_steady(4'h6, 4'hF);
    t_square();
    t_rows_only();
    t_quiet();
    complete_run();
  end

  // Worst case run is near 90000 cycles
  initial begin
    repeat (99000) @(posedge ref_clk);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
